// File: tws_pkg.sv
// Summary of operation
// - Upper seven own-address bits form slave address.
// - Own-address bit zero enables general call answer.
// - Software enables interface, clears start and stop.
// - Address acknowledged only while acknowledge enable set.
// - Direction bit zero receives; one is not acknowledged and raises the read event.
// - Own address plus write sets flag and status.
// - Addressed after lost arbitration reports 0x68 or 0x78.
// - Acknowledge enable cleared gives not-acknowledge next byte.
// - Acknowledge enable zero ignores address, keeps monitoring.
// - Asleep, address still recognised from bus clock.
// - Match during sleep wakes, holds clock until cleared.
// - Writing one to flag clears it, releasing clock.
// - Data register not updated by wake-up match.
// - Software masks prescaler bits when comparing status.
// - Own address write acknowledged reports status 0x60.
package tws_pkg;

  // ==========================================================
  // Register map of the slave receiver
  localparam logic [2:0] REG_OWN_ADDR = 3'h0;
  localparam logic [2:0] REG_CONTROL = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_DATA = 3'h3;
  localparam logic [2:0] REG_EVENT = 3'h4;
  localparam logic [2:0] REG_MASK = 3'h5;

  // ==========================================================
  // Control register field positions and reset values of own address, status and event registers
  localparam int CTL_FLAG = 7;
  localparam int CTL_ACK = 6;
  localparam int CTL_STA = 5;
  localparam int CTL_STO = 4;
  localparam int CTL_WCOL = 3;
  localparam int CTL_EN = 2;
  localparam int CTL_IE = 0;
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'hf8;
  localparam logic [3:0] EVENT_RST = 4'h0;

  // ==========================================================
  // Event bits of the sticky event register
  localparam int EV_FLAG = 0;
  localparam int EV_STOP = 1;
  localparam int EV_READ = 2;
  localparam int EV_WAKE = 3;

  // ==========================================================
  // Status codes and status masks of the receiving slave
  localparam logic [7:0] ST_OWN_W = 8'h60;
  localparam logic [7:0] ST_ARB_OWN = 8'h68;
  localparam logic [7:0] ST_GC = 8'h70;
  localparam logic [7:0] ST_ARB_GC = 8'h78;
  localparam logic [7:0] ST_DATA_ACK = 8'h80;
  localparam logic [7:0] ST_DATA_NACK = 8'h88;
  localparam logic [7:0] ST_GC_ACK = 8'h90;
  localparam logic [7:0] ST_GC_NACK = 8'h98;
  localparam logic [7:0] ST_STOP = 8'ha0;
  localparam logic [7:0] ST_CODE_MASK = 8'hf8;
  localparam logic [7:0] ST_PRESC_MASK = 8'h03;

  // ==========================================================
  // Bit timing of the master end
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = SCL_HALF_NS / CLK_PERIOD_NS;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ==========================================================
  // State encodings
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_ADDR = 6'b000010,
    S_AACK = 6'b000100,
    S_HOLD = 6'b001000,
    S_DATA = 6'b010000,
    S_DACK = 6'b100000
  } tws_sstate_type;

  typedef enum logic [5:0] {
    M_IDLE = 6'b000001,
    M_START = 6'b000010,
    M_LOW = 6'b000100,
    M_HIGH = 6'b001000,
    M_STOP = 6'b010000,
    M_STOP2 = 6'b100000
  } tws_mstate_type;

endpackage

// File: tws_if.sv
`timescale 1ns/1ns
// ==========================================================
// Two-wire link with open-drain clock and data lines.
interface tws_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic scl_s_o;
  logic scl_s_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // A line is low while any enabled driver pulls it low.
  assign scl = !((scl_m_oe && !scl_m_o) || (scl_s_oe && !scl_s_o));
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

  modport master (
    input scl, sda,
    output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe
  );
  modport device (
    input scl, sda,
    output scl_s_o, scl_s_oe, sda_s_o, sda_s_oe
  );
endinterface

// File: tws_sync.sv
`timescale 1ns/1ns
// ==========================================================
// Two-stage synchroniser for pin levels.
module tws_sync #(
  parameter int W = 2
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage; lines idle high.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= '1;
      o_sync <= '1;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule // tws_sync

// File: tws_slave.sv
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
// ==========================================================
// Slave receiver end of the two-wire link.
module tws_slave (
  // Clock and reset.
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  // Two-wire link.
  tws_if.device LINK,
  // Register port.
  input wire logic [2:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // System status.
  input wire logic I_SLEEP,
  input wire logic I_ARB_LOST,
  output logic O_IRQ,
  output logic O_WAKE
);
  import tws_pkg::*;

  // ==========================================================
  // Pin sampling and bus condition detection
  logic [1:0] pins_s;
  logic scl_q_r;
  logic sda_q_r;
  tws_sync #(.W(2)) tws_sync_inst (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_async({LINK.scl, LINK.sda}),
    .o_sync(pins_s)
  );
  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];
  wire scl_rise = scl_s && !scl_q_r;
  wire scl_fall = !scl_s && scl_q_r;
  wire start_det = scl_s && scl_q_r && sda_q_r && !sda_s;
  wire stop_det = scl_s && scl_q_r && !sda_q_r && sda_s;

  // ==========================================================
  // Registers
  tws_sstate_type state_r, state_nxt;
  logic [7:0] own_r;
  logic flag_r, ack_en_r, sta_r, sto_r, wcol_r, en_r, ie_r;
  logic [7:0] code_r;
  logic [1:0] presc_r;
  logic [7:0] data_r;
  logic [7:0] shift_r, shift_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic sda_drv_r, sda_drv_nxt;
  logic gc_r, arb_r;
  logic wake_r;
  logic [3:0] ev_r, mask_r;
  logic set_flag, read_evt, stop_evt, data_load;
  logic [7:0] code_nxt;

  // ==========================================================
  // Register port decode
  wire wr_own = I_WR && (I_ADDR == REG_OWN_ADDR);
  wire wr_ctl = I_WR && (I_ADDR == REG_CONTROL);
  wire wr_sts = I_WR && (I_ADDR == REG_STATUS);
  wire wr_dat = I_WR && (I_ADDR == REG_DATA);
  wire wr_ev = I_WR && (I_ADDR == REG_EVENT);
  wire wr_msk = I_WR && (I_ADDR == REG_MASK);
  wire flag_clr = wr_ctl && I_WDATA[CTL_FLAG];
  wire [7:0] ctl_rd = {flag_r, ack_en_r, sta_r, sto_r, wcol_r, en_r, 1'b0, ie_r};
  wire [7:0] sts_rd = (code_r & ST_CODE_MASK) | {6'h00, presc_r};
  wire [7:0] rd_mux = (I_ADDR == REG_OWN_ADDR) ? own_r :
                      (I_ADDR == REG_CONTROL) ? ctl_rd :
                      (I_ADDR == REG_STATUS) ? sts_rd :
                      (I_ADDR == REG_DATA) ? data_r :
                      (I_ADDR == REG_EVENT) ? {4'h0, ev_r} :
                      (I_ADDR == REG_MASK) ? {4'h0, mask_r} : 8'h00;

  // ==========================================================
  // Address matching
  wire addr_hit = (shift_r[7:1] == own_r[7:1]);
  wire is_gc = (shift_r[7:1] == 7'h00);
  wire gc_hit = is_gc && own_r[0];
  wire match_ok = en_r && ack_en_r && (addr_hit || gc_hit);
  wire addressed = (state_r == S_HOLD) || (state_r == S_DATA) || (state_r == S_DACK);
  wire [7:0] addr_code = arb_r ? (gc_r ? ST_ARB_GC : ST_ARB_OWN) :
                         (gc_r ? ST_GC : ST_OWN_W);
  wire [7:0] data_code = sda_drv_r ? (gc_r ? ST_GC_ACK : ST_DATA_ACK) :
                         (gc_r ? ST_GC_NACK : ST_DATA_NACK);

  // Bus state machine: address, acknowledge, hold and data phases.
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    sda_drv_nxt = sda_drv_r;
    set_flag = 1'b0;
    read_evt = 1'b0;
    stop_evt = 1'b0;
    data_load = 1'b0;
    code_nxt = code_r;
    if (!en_r) begin
      state_nxt = S_IDLE;
      sda_drv_nxt = 1'b0;
    end else if (stop_det || start_det) begin
      state_nxt = stop_det ? S_IDLE : S_ADDR;
      cnt_nxt = 4'h0;
      sda_drv_nxt = 1'b0;
      if (addressed) begin
        set_flag = 1'b1;
        stop_evt = 1'b1;
        code_nxt = ST_STOP;
      end
    end else begin
      case (state_r)
        S_IDLE: begin
          state_nxt = S_IDLE;
        end
        S_ADDR, S_DATA: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
            if (state_r == S_DATA) begin
              data_load = 1'b1;
              sda_drv_nxt = ack_en_r;
              state_nxt = S_DACK;
            end else if (match_ok && !shift_r[0]) begin
              sda_drv_nxt = 1'b1;
              state_nxt = S_AACK;
            end else begin
              read_evt = match_ok;
              state_nxt = S_IDLE;
            end
          end
        end
        S_AACK: begin
          if (scl_fall) begin
            sda_drv_nxt = 1'b0;
            set_flag = 1'b1;
            code_nxt = addr_code;
            cnt_nxt = 4'h0;
            state_nxt = S_HOLD;
          end
        end
        S_HOLD: begin
          if (!flag_r) begin
            state_nxt = S_DATA;
          end
        end
        S_DACK: begin
          if (scl_fall) begin
            sda_drv_nxt = 1'b0;
            set_flag = 1'b1;
            code_nxt = data_code;
            cnt_nxt = 4'h0;
            state_nxt = sda_drv_r ? S_HOLD : S_IDLE;
          end
        end
        default: begin
          state_nxt = S_IDLE;
        end
      endcase
    end
  end

  // Bus state and shift registers.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_r <= S_IDLE;
      shift_r <= 8'h00;
      cnt_r <= 4'h0;
      sda_drv_r <= 1'b0;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      code_r <= STATUS_RST;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      sda_drv_r <= sda_drv_nxt;
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
      code_r <= code_nxt;
    end
  end

  // Kind of addressing, latched when the address is acknowledged.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      gc_r <= 1'b0;
      arb_r <= 1'b0;
    end else if (state_r == S_ADDR && state_nxt == S_AACK) begin
      gc_r <= is_gc;
      arb_r <= I_ARB_LOST;
    end
  end

  // Control and address registers; a hardware set beats a clear.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      own_r <= OWN_ADDR_RST;
      flag_r <= 1'b0;
      {ack_en_r, sta_r, sto_r, en_r, ie_r} <= 5'h00;
      presc_r <= 2'h0;
    end else begin
      flag_r <= set_flag || (flag_r && !flag_clr);
      if (wr_own) begin
        own_r <= I_WDATA;
      end
      if (wr_ctl) begin
        ack_en_r <= I_WDATA[CTL_ACK];
        sta_r <= I_WDATA[CTL_STA];
        sto_r <= I_WDATA[CTL_STO];
        en_r <= I_WDATA[CTL_EN];
        ie_r <= I_WDATA[CTL_IE];
      end
      if (wr_sts) begin
        presc_r <= I_WDATA[1:0];
      end
    end
  end

  // Data register and write collision; a wake-up match loads nothing.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      data_r <= 8'h00;
      wcol_r <= 1'b0;
    end else begin
      if (data_load) begin
        data_r <= shift_r;
      end else if (wr_dat) begin
        data_r <= I_WDATA;
      end
      if (wr_dat) begin
        wcol_r <= !flag_r;
      end
    end
  end

  // Wake request, sticky events, mask and read data.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wake_r <= 1'b0;
      ev_r <= EVENT_RST;
      mask_r <= EVENT_RST;
      O_RDATA <= 8'h00;
    end else begin
      if (set_flag && state_r == S_AACK && I_SLEEP) begin
        wake_r <= 1'b1;
      end else if (!flag_r) begin
        wake_r <= 1'b0;
      end
      ev_r <= {set_flag && state_r == S_AACK && I_SLEEP, read_evt, stop_evt, set_flag}
              | (ev_r & ~(wr_ev ? I_WDATA[3:0] : 4'h0));
      if (wr_msk) begin
        mask_r <= I_WDATA[3:0];
      end
      O_RDATA <= I_RD ? rd_mux : 8'h00;
    end
  end

  // ==========================================================
  // Outputs and line drivers
  assign O_IRQ = |(ev_r & mask_r);
  assign O_WAKE = wake_r;
  assign LINK.scl_s_o = 1'b0;
  assign LINK.sda_s_o = 1'b0;
  assign LINK.scl_s_oe = (state_r == S_HOLD) && flag_r;
  assign LINK.sda_s_oe = sda_drv_r;
endmodule // tws_slave

// File: tws_master.sv
`timescale 1ns/1ns
// ==========================================================
// Master transmitter end of the two-wire link.
module tws_master #(
  parameter int HALF = tws_pkg::SCL_HALF_CYC
) (
  // Clock and reset.
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  // Two-wire link.
  tws_if.master LINK,
  // Transfer request.
  input wire logic I_GO,
  input wire logic [6:0] I_ADDR,
  input wire logic I_RNW,
  // Data bytes after the address.
  input wire logic [7:0] I_DATA,
  input wire logic I_VALID,
  output logic O_READY,
  // Transfer status.
  output logic O_BUSY,
  output logic O_NACK,
  output logic O_DONE
);
  import tws_pkg::*;

  logic [1:0] pins_s;
  tws_mstate_type state_r;
  logic [15:0] cnt_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic rnw_r;
  logic scl_oe_r, sda_oe_r;

  tws_sync #(.W(2)) tws_sync_inst (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_async({LINK.scl, LINK.sda}),
    .o_sync(pins_s)
  );

  // ==========================================================
  // Phase decode
  wire half_done = (cnt_r == 16'(HALF - 1));
  wire ack_end = (state_r == M_HIGH) && pins_s[1] && half_done && (bit_r == BITS_PER_BYTE);
  wire take = O_READY && I_VALID;
  assign O_READY = ack_end && !pins_s[0] && !rnw_r;

  // Bit sequencer; a stretched clock keeps the high phase counter at zero.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_r <= M_IDLE;
      cnt_r <= 16'h0000;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      rnw_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      O_NACK <= 1'b0;
      O_DONE <= 1'b0;
    end else begin
      O_DONE <= 1'b0;
      cnt_r <= half_done ? 16'h0000 : cnt_r + 16'h0001;
      case (state_r)
        M_IDLE: begin
          cnt_r <= 16'h0000;
          if (I_GO) begin
            shift_r <= {I_ADDR, I_RNW};
            rnw_r <= I_RNW;
            sda_oe_r <= 1'b1;
            O_NACK <= 1'b0;
            state_r <= M_START;
          end
        end
        M_START: begin
          if (half_done) begin
            scl_oe_r <= 1'b1;
            bit_r <= 4'h0;
            state_r <= M_LOW;
          end
        end
        M_LOW: begin
          sda_oe_r <= (bit_r != BITS_PER_BYTE) && !shift_r[7];
          if (half_done) begin
            scl_oe_r <= 1'b0;
            state_r <= M_HIGH;
          end
        end
        M_HIGH: begin
          if (!pins_s[1]) begin
            cnt_r <= 16'h0000;
          end else if (half_done) begin
            scl_oe_r <= 1'b1;
            if (bit_r != BITS_PER_BYTE) begin
              bit_r <= bit_r + 4'h1;
              shift_r <= {shift_r[6:0], 1'b0};
              state_r <= M_LOW;
            end else if (take) begin
              bit_r <= 4'h0;
              shift_r <= I_DATA;
              state_r <= M_LOW;
            end else begin
              O_NACK <= pins_s[0];
              state_r <= M_STOP;
            end
          end
        end
        M_STOP: begin
          sda_oe_r <= 1'b1;
          if (half_done) begin
            scl_oe_r <= 1'b0;
            state_r <= M_STOP2;
          end
        end
        M_STOP2: begin
          if (!pins_s[1]) begin
            cnt_r <= 16'h0000;
          end else if (half_done) begin
            sda_oe_r <= 1'b0;
            O_DONE <= 1'b1;
            state_r <= M_IDLE;
          end
        end
        default: begin
          state_r <= M_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs and line drivers
  assign O_BUSY = (state_r != M_IDLE);
  assign LINK.scl_m_o = 1'b0;
  assign LINK.sda_m_o = 1'b0;
  assign LINK.scl_m_oe = scl_oe_r;
  assign LINK.sda_m_oe = sda_oe_r;
endmodule // tws_master

// File: tws_assertions.sv
`timescale 1ns/1ns
// ==========================================================
// Checks on what the slave end drives onto the link.
module tws_assertions (
  // Clock and reset.
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  // Link lines and slave drivers.
  input wire logic scl,
  input wire logic scl_s_o,
  input wire logic sda_s_o,
  input wire logic scl_s_oe,
  input wire logic sda_s_oe
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  // ==========================================================
  // Acknowledge timing.
  property p_ack_rise;
    $rose(sda_s_oe) |-> !scl && $past(scl, 6);
  endproperty
  a_ack_rise: assert property (p_ack_rise)
    else $error("ack raised outside early low phase");
  property p_ack_fall;
    $fell(sda_s_oe) |-> !scl && $past(scl, 6);
  endproperty
  a_ack_fall: assert property (p_ack_fall)
    else $error("ack released outside early low phase");
  property p_ack_len;
    $rose(sda_s_oe) |=> sda_s_oe [*8];
  endproperty
  a_ack_len: assert property (p_ack_len)
    else $error("ack shorter than a clock high phase");
  property p_sda_stable;
    scl && $past(scl) |-> $stable(sda_s_oe);
  endproperty
  a_sda_stable: assert property (p_sda_stable)
    else $error("slave data changed while clock high");

  // ==========================================================
  // Clock stretching and idle levels.
  property p_hold_rise;
    $rose(scl_s_oe) |-> !scl && $past(scl, 6);
  endproperty
  a_hold_rise: assert property (p_hold_rise)
    else $error("stretch began outside early low phase");
  property p_hold_after_ack;
    $rose(scl_s_oe) |-> $past(sda_s_oe, 8);
  endproperty
  a_hold_after_ack: assert property (p_hold_after_ack)
    else $error("stretch without a preceding ack");
  property p_hold_rel;
    $fell(scl_s_oe) |-> !sda_s_oe;
  endproperty
  a_hold_rel: assert property (p_hold_rel)
    else $error("data held low when stretch ended");
  property p_reset_idle;
    $rose(I_RST_N) |-> !sda_s_oe && !scl_s_oe ##1 !sda_s_oe && !scl_s_oe;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("slave drives the link after reset");
  property p_open_drain;
    scl_s_o == 1'b0 && sda_s_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("slave drives a line high");
endmodule // tws_assertions

// File: tb_two_wire_slave_receiver.sv
`timescale 1ns/1ns
// ==========================================================
// Bench: master end talks to the slave end over one link.
module tb_two_wire_slave_receiver;
  import tws_pkg::*;
  logic clk = 1'b0;
  logic rst_n, s_wr, s_rd, sleep, arb, irq, wake, rd_seen;
  logic m_go, m_rnw, m_valid, m_ready, m_busy, m_nack, m_done;
  logic [2:0] s_addr;
  logic [7:0] s_wdata, s_rdata, m_data;
  logic [6:0] m_addr, own;
  logic [7:0] dat [4];
  logic [7:0] eq [$];
  logic [7:0] mq [$];
  int nb, bi, n_go, n_done, err_total, cmp_count;

  // Clock generation.
  always #5 clk = ~clk;

  tws_if link ();
  tws_slave tws_slave_inst (.I_CLOCK(clk), .I_RST_N(rst_n), .LINK(link), .I_ADDR(s_addr),
    .I_WDATA(s_wdata), .I_WR(s_wr), .I_RD(s_rd), .O_RDATA(s_rdata), .I_SLEEP(sleep),
    .I_ARB_LOST(arb), .O_IRQ(irq), .O_WAKE(wake));
  tws_master #(.HALF(8)) tws_master_inst (.I_CLOCK(clk), .I_RST_N(rst_n), .LINK(link),
    .I_GO(m_go), .I_ADDR(m_addr), .I_RNW(m_rnw), .I_DATA(m_data), .I_VALID(m_valid),
    .O_READY(m_ready), .O_BUSY(m_busy), .O_NACK(m_nack), .O_DONE(m_done));
  tws_assertions tws_assertions_inst (.I_CLOCK(clk), .I_RST_N(rst_n), .scl(link.scl),
    .scl_s_o(link.scl_s_o), .sda_s_o(link.sda_s_o), .scl_s_oe(link.scl_s_oe),
    .sda_s_oe(link.sda_s_oe));

  // ==========================================================
  // Comparison, verdict and register port tasks.
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude;
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    s_addr <= a;
    s_wdata <= d;
    s_wr <= 1'b1;
    @(posedge clk);
    s_wr <= 1'b0;
  endtask

  // Notes the expected read value; the monitor compares it.
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    eq.push_back(e);
    mq.push_back(m);
    @(posedge clk);
    s_addr <= a;
    s_rd <= 1'b1;
    @(posedge clk);
    s_rd <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  always @(posedge clk) begin
    if (rd_seen) chk("rdata", s_rdata & mq.pop_front(), eq.pop_front());
    if (m_done === 1'b1) n_done++;
    rd_seen <= s_rd;
  end

  // ==========================================================
  // Link level helpers.
  task automatic idle;
    int i;
    for (i = 0; i < 4000; i++) begin
      #1;
      if (m_busy === 1'b0) break;
      @(posedge clk);
    end
    chk("busy", {7'h0, m_busy}, 8'h00);
  endtask

  task automatic go(input logic [6:0] a, input logic r, input int n);
    int k;
    idle();
    for (k = 0; k < 4; k++) dat[k] = 8'($urandom);
    nb = n;
    bi = 0;
    n_go++;
    @(posedge clk);
    m_addr <= a;
    m_rnw <= r;
    m_data <= dat[0];
    m_valid <= (n > 0);
    m_go <= 1'b1;
    @(posedge clk);
    m_go <= 1'b0;
  endtask

  // Hands the master its next byte when it asks.
  always @(posedge clk) begin
    if (m_ready && m_valid) begin
      bi = bi + 1;
      m_data <= dat[bi];
      m_valid <= (bi < nb);
    end
  end

  task automatic flag(input logic [7:0] st, input logic hold);
    int i;
    for (i = 0; i < 4000 && irq !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("irq", {7'h0, irq}, 8'h01);
    rd(REG_STATUS, st, ST_CODE_MASK);
    if (hold) begin
      @(posedge clk);
      chk("scl", {7'h0, link.scl}, 8'h00);
    end
  endtask

  task automatic clr(input logic [7:0] c);
    wr(REG_EVENT, 8'h0f);
    wr(REG_CONTROL, c);
  endtask

  task automatic addr_only(input logic [6:0] a, input logic [7:0] st);
    go(a, 1'b0, 0);
    flag(st, 1'b1);
    clr(8'hc4);
    flag(ST_STOP, 1'b0);
    clr(8'hc4);
  endtask

  task automatic refused(input logic [6:0] a, input logic r);
    go(a, r, 0);
    idle();
    chk("nack", {7'h0, m_nack}, 8'h01);
    chk("irq", {7'h0, irq}, 8'h00);
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    {s_wr, s_rd, sleep, arb, m_go, m_rnw, m_valid, rd_seen} = 8'h00;
    {s_addr, s_wdata, m_data, m_addr} = 26'h0;
    err_total = 0;
    cmp_count = 0;
    void'($urandom(32'hb356));
    own = {1'b1, 6'($urandom)};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_STATUS, STATUS_RST);
    rd(REG_CONTROL, 8'h00);
    // Prescaler bits read back; later status checks mask them off.
    wr(REG_STATUS, ST_PRESC_MASK);
    rd(REG_STATUS, STATUS_RST | ST_PRESC_MASK);
    wr(3'h6, 8'hff);
    rd(3'h6, 8'h00);
    wr(REG_OWN_ADDR, {own, 1'b1});
    rd(REG_OWN_ADDR, {own, 1'b1});
    wr(REG_MASK, 8'h01);
    wr(REG_CONTROL, 8'h44);
    // Own address, one byte acked, then acknowledge withdrawn.
    go(own, 1'b0, 2);
    flag(ST_OWN_W, 1'b1);
    clr(8'hc4);
    flag(ST_DATA_ACK, 1'b1);
    rd(REG_DATA, dat[0]);
    clr(8'h84);
    flag(ST_DATA_NACK, 1'b0);
    clr(8'hc4);
    idle();
    chk("nack", {7'h0, m_nack}, 8'h01);
    // General call with one byte.
    go(7'h00, 1'b0, 1);
    flag(ST_GC, 1'b1);
    clr(8'hc4);
    flag(ST_GC_ACK, 1'b1);
    clr(8'hc4);
    flag(ST_STOP, 1'b0);
    clr(8'hc4);
    // Addressed after the own master lost arbitration, then refusals and a plain own-address match.
    arb <= 1'b1;
    addr_only(own, ST_ARB_OWN);
    addr_only(7'h00, ST_ARB_GC);
    arb <= 1'b0;
    refused(own ^ 7'h01, 1'b0);
    wr(REG_CONTROL, 8'h04);
    refused(own, 1'b0);
    wr(REG_CONTROL, 8'h44);
    addr_only(own, ST_OWN_W);
    wr(REG_OWN_ADDR, {own, 1'b0});
    refused(7'h00, 1'b0);
    // Read direction: not received, event raised but masked.
    refused(own, 1'b1);
    rd(REG_EVENT, 8'h04);
    wr(REG_MASK, 8'h05);
    #1 chk("irq", {7'h0, irq}, 8'h01);
    wr(REG_EVENT, 8'h04);
    #1 chk("irq", {7'h0, irq}, 8'h00);
    // Match while asleep wakes the part and stretches the clock.
    sleep <= 1'b1;
    go(own, 1'b0, 0);
    flag(ST_OWN_W, 1'b1);
    chk("wake", {7'h0, wake}, 8'h01);
    clr(8'hc4);
    @(posedge clk);
    #1 chk("wake", {7'h0, wake}, 8'h00);
    flag(ST_STOP, 1'b0);
    clr(8'hc4);
    sleep <= 1'b0;
    // Every transfer must have ended with a stop and a done pulse.
    idle();
    chk("done", 8'(n_done), 8'(n_go));
    conclude();
  end

  // Watchdog against a hung transfer.
  initial begin
    #300_000;
    err_total++;
    conclude();
  end
endmodule // tb_two_wire_slave_receiver
